// ---- verilog/tmc_timer2.sv ----
// Summary of operation
// RULE1: Low byte overflow raises interrupt only when its enable and the mask allow.
// RULE2: With capture enabled and unmasked, each oscillator falling edge raises an interrupt.
// RULE3: On a capturing falling edge the whole 16-bit count is copied to reload.
// RULE4: Split bit picks one 16-bit reload timer or two 8-bit reload timers.
// RULE5: Run bit stops or starts counting; in 16-bit mode it gates the whole counter.
// RULE6: In split mode run gates only the high byte; low byte always counts.
// RULE7: Control bit 1 reads zero and ignores writes.
// RULE8: External clock select picks the external source, shared by both bytes.
// RULE9: Per-byte clock selects choose system clock or the chosen external clock.
// RULE10: External clock select zero gives system clock divided by twelve.
// RULE11: Low byte wrap from 0xff sets the low overflow flag; only software clears it.
// RULE12: In 16-bit mode a full overflow reloads the counter on the same tick.
`timescale 1ns/1ps
`default_nettype none
`include "tmc_cfg.svh"

module tmc_timer2 #(
  parameter int DIV_RATIO = `TMC_DIV_RATIO
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ext_clk_i,
  input wire logic lfo_i,
  output tmc_pkg::tmc_word_t count_o,
  output logic irq_o
);
  import tmc_pkg::*;

  // The prescaler and its spacing check cannot serve ratios outside this span
  if (DIV_RATIO < 2 || DIV_RATIO > 256) begin : g_bad_ratio
    $error("tmc_timer2: DIV_RATIO must lie between 2 and 256");
  end

  tmc_tick_if tk ();

  tmc_tick_gen #(
    .DIV_RATIO(DIV_RATIO)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ext_clk_i(ext_clk_i),
    .lfo_i(lfo_i),
    .tk(tk.src)
  );

  // Bus decode
  logic req, wr_acc;
  logic hit_ctrl, hit_cnt, hit_rld, hit_ckc, hit_st, hit_mask;
  logic [7:0] adr_w;

  assign req = wb_cyc_i & wb_stb_i;
  assign adr_w = {wb_adr_i[7:2], 2'b00};
  // Writes land on the edge where the master sees ack
  assign wr_acc = req & wb_we_i & wb_ack_o;
  assign hit_ctrl = (adr_w == `TMC_ADR_CTRL);
  assign hit_cnt = (adr_w == `TMC_ADR_CNT);
  assign hit_rld = (adr_w == `TMC_ADR_RLD);
  assign hit_ckc = (adr_w == `TMC_ADR_CKC);
  assign hit_st = (adr_w == `TMC_ADR_STAT);
  assign hit_mask = (adr_w == `TMC_ADR_MASK);

  // Configuration registers
  tmc_byte_t ctrl_q, ctrl_d;
  logic [1:0] ckc_q, ckc_d;
  tmc_stat_t mask_q, mask_d;

  always_comb begin
    tmc_byte_t wv;
    wv = tmc_merge8(ctrl_q, wb_dat_i[7:0], wr_acc & hit_ctrl & wb_sel_i[0]);
    // Unused bit and upper bits never store
    ctrl_d = wv & `TMC_CTRL_WMASK; // [RULE7]
    ckc_d = ckc_q;
    mask_d = mask_q;
    if (wr_acc && hit_ckc && wb_sel_i[0]) begin
      ckc_d = wb_dat_i[1:0];
    end
    if (wr_acc && hit_mask && wb_sel_i[0]) begin
      mask_d = wb_dat_i[2:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= `TMC_CTRL_RST;
      ckc_q <= `TMC_CKC_RST;
      mask_q <= `TMC_MASK_RST;
    end else begin
      ctrl_q <= ctrl_d;
      ckc_q <= ckc_d;
      mask_q <= mask_d;
    end
  end

  logic run, split, cap_en, lbie;
  assign run = ctrl_q[`TMC_CTRL_RUN];
  assign split = ctrl_q[`TMC_CTRL_SPLIT];
  assign cap_en = ctrl_q[`TMC_CTRL_CAPEN];
  assign lbie = ctrl_q[`TMC_CTRL_LBIE];

  // Tick selection
  logic ext_tick, tick_lo, tick_hi;
  // One external source serves both bytes, even in split mode
  assign ext_tick = ctrl_q[`TMC_CTRL_ECS] ? tk.ext_rise : tk.div_tick; // [RULE8] [RULE10]
  assign tick_lo = ckc_q[`TMC_CKC_LO] ? 1'b1 : ext_tick; // [RULE9]
  assign tick_hi = ckc_q[`TMC_CKC_HI] ? 1'b1 : ext_tick; // [RULE9]

  // Counter and reload
  tmc_word_t cnt_q, cnt_d, rld_q, rld_d;
  logic lo_en, hi_en, lo_wrap, hi_wrap, cap_ev;

  // Low byte free-runs in split mode; run gates it only as part of the 16-bit counter
  assign lo_en = split ? tick_lo : (run & tick_lo); // [RULE5] [RULE6]
  assign hi_en = split & run & tick_hi; // [RULE6]
  assign lo_wrap = lo_en && (cnt_q[7:0] == 8'hff); // [RULE11]
  assign hi_wrap = split ? (hi_en && (cnt_q[15:8] == 8'hff))
                         : (lo_en && (cnt_q == 16'hffff));
  assign cap_ev = cap_en & tk.lfo_fall;

  always_comb begin
    logic wr_c0, wr_c1, wr_r0, wr_r1;
    wr_c0 = wr_acc & hit_cnt & wb_sel_i[0];
    wr_c1 = wr_acc & hit_cnt & wb_sel_i[1];
    wr_r0 = wr_acc & hit_rld & wb_sel_i[0];
    wr_r1 = wr_acc & hit_rld & wb_sel_i[1];
    cnt_d = cnt_q;
    if (!split) begin // [RULE4]
      if (lo_en) begin // [RULE5]
        if (cnt_q == 16'hffff) begin
          cnt_d = rld_q; // [RULE12]
        end else begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
    end else begin
      if (lo_en) begin // [RULE4]
        cnt_d[7:0] = lo_wrap ? rld_q[7:0] : cnt_q[7:0] + 8'h01;
      end
      if (hi_en) begin // [RULE6]
        cnt_d[15:8] = hi_wrap ? rld_q[15:8] : cnt_q[15:8] + 8'h01;
      end
    end
    // Software writes override the tick in the same cycle
    cnt_d[7:0] = tmc_merge8(cnt_d[7:0], wb_dat_i[7:0], wr_c0);
    cnt_d[15:8] = tmc_merge8(cnt_d[15:8], wb_dat_i[15:8], wr_c1);
    rld_d[7:0] = tmc_merge8(rld_q[7:0], wb_dat_i[7:0], wr_r0);
    rld_d[15:8] = tmc_merge8(rld_q[15:8], wb_dat_i[15:8], wr_r1);
    // Capture beats a colliding reload write so no edge is lost
    if (cap_ev) begin
      rld_d = cnt_q; // [RULE3]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= `TMC_CNT_RST;
      rld_q <= `TMC_RLD_RST;
    end else begin
      cnt_q <= cnt_d;
      rld_q <= rld_d;
    end
  end

  assign count_o = cnt_q;

  // Status, interrupt
  tmc_stat_t st_q, st_d, ev, clr, gate_d;
  logic irq_q, irq_d;

  always_comb begin
    ev = '0;
    ev[`TMC_ST_HI] = hi_wrap;
    ev[`TMC_ST_LO] = lo_wrap; // [RULE11]
    ev[`TMC_ST_CAP] = cap_ev; // [RULE2]
    clr = (wr_acc && hit_st && wb_sel_i[0]) ? wb_dat_i[2:0] : '0;
    // A new event in the clearing cycle survives
    st_d = (st_q & ~clr) | ev; // [RULE11]
    gate_d = '0;
    gate_d[`TMC_ST_HI] = 1'b1;
    gate_d[`TMC_ST_LO] = ctrl_d[`TMC_CTRL_LBIE]; // [RULE1]
    gate_d[`TMC_ST_CAP] = ctrl_d[`TMC_CTRL_CAPEN]; // [RULE2]
    irq_d = |(st_d & mask_d & gate_d); // [RULE1] [RULE2]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= `TMC_ST_RST;
      irq_q <= 1'b0;
    end else begin
      st_q <= st_d;
      irq_q <= irq_d;
    end
  end

  assign irq_o = irq_q;

  // Wishbone answer: ack one cycle after the request, dropped the next cycle
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d, rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux[7:0] = ctrl_q & `TMC_CTRL_WMASK; // [RULE7]
    end else if (hit_cnt) begin
      rd_mux[15:0] = cnt_q;
    end else if (hit_rld) begin
      rd_mux[15:0] = rld_q;
    end else if (hit_ckc) begin
      rd_mux[1:0] = ckc_q;
    end else if (hit_st) begin
      rd_mux[2:0] = st_q;
    end else if (hit_mask) begin
      rd_mux[2:0] = mask_q;
    end
    ack_d = req & ~ack_q;
    dat_d = (ack_d && !wb_we_i) ? rd_mux : 32'h0000_0000;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // Checks
  logic cnt_wr, rld_wr;
  assign cnt_wr = wr_acc & hit_cnt;
  assign rld_wr = wr_acc & hit_rld;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_capture;
    cap_en && tk.lfo_fall;
  endsequence

  sequence s_full_wrap;
    !split && lo_en && (cnt_q == 16'hffff) && !cnt_wr;
  endsequence

  // One external edge must move both bytes in split mode
  sequence s_ext_both;
    split && run && ctrl_q[`TMC_CTRL_ECS] && (ckc_q == 2'b00) && tk.ext_rise && !cnt_wr
      && (cnt_q[7:0] != 8'hff) && (cnt_q[15:8] != 8'hff);
  endsequence

  a_lo_irq_req: assert property ( // [RULE1]
    ($rose(st_q[`TMC_ST_LO]) && mask_q[`TMC_ST_LO] && lbie) |-> irq_o)
    else $error("low byte overflow did not raise interrupt");

  a_irq_has_cause: assert property ( // [RULE1]
    irq_o |-> (st_q[`TMC_ST_HI] && mask_q[`TMC_ST_HI])
    || (st_q[`TMC_ST_LO] && mask_q[`TMC_ST_LO] && lbie)
    || (st_q[`TMC_ST_CAP] && mask_q[`TMC_ST_CAP] && cap_en))
    else $error("interrupt raised without enabled cause");

  a_cap_irq: assert property ( // [RULE2]
    (s_capture ##0 (mask_q[`TMC_ST_CAP] && !wr_acc)) |=> (irq_o && st_q[`TMC_ST_CAP]))
    else $error("capture edge did not raise interrupt");

  a_cap_copy: assert property (s_capture |=> (rld_q == $past(cnt_q))) // [RULE3]
    else $error("capture did not copy count");

  a_split_lo_wrap: assert property ( // [RULE4]
    (split && lo_wrap && !cnt_wr) |=> (cnt_q[7:0] == $past(rld_q[7:0])))
    else $error("split low byte did not reload");

  a_run_stop16: assert property ((!split && !run && !cnt_wr) |=> $stable(cnt_q)) // [RULE5]
    else $error("stopped 16-bit counter moved");

  a_hi_gate: assert property ((split && !run && !cnt_wr) |=> $stable(cnt_q[15:8])) // [RULE6]
    else $error("high byte counted while stopped");

  a_lo_free: assert property ( // [RULE6]
    (split && !run && tick_lo && !cnt_wr && cnt_q[7:0] != 8'hff)
    |=> (cnt_q[7:0] == $past(cnt_q[7:0]) + 8'h01))
    else $error("split low byte did not count");

  a_unused_bit: assert property ((wb_ack_o && !wb_we_i && hit_ctrl) |-> !wb_dat_o[1]) // [RULE7]
    else $error("unused control bit read nonzero");

  a_sys_clk_sel: assert property ( // [RULE9]
    (ckc_q[`TMC_CKC_LO] && !split && run && !cnt_wr && cnt_q != 16'hffff)
    |=> (cnt_q == $past(cnt_q) + 16'h0001))
    else $error("system clock select did not count every cycle");

  a_lo_ovf_flag: assert property (lo_wrap |=> st_q[`TMC_ST_LO] [*1]) // [RULE11]
    else $error("low overflow flag not set");

  a_reload16: assert property (s_full_wrap |=> (cnt_q == $past(rld_q))) // [RULE12]
    else $error("16-bit overflow did not reload");

  // Counting paths that the checks above do not cover
  a_carry16: assert property ( // [RULE4]
    (!split && lo_en && cnt_q[7:0] == 8'hff && cnt_q[15:8] != 8'hff && !cnt_wr)
    |=> (cnt_q == {$past(cnt_q[15:8]) + 8'h01, 8'h00}))
    else $error("16-bit counter did not carry into high byte");

  a_split_hi_wrap: assert property ( // [RULE4]
    (split && hi_en && cnt_q[15:8] == 8'hff && !cnt_wr)
    |=> (cnt_q[15:8] == $past(rld_q[15:8])))
    else $error("split high byte did not reload");

  a_ckc_hi_sel: assert property ( // [RULE9]
    (split && run && ckc_q[`TMC_CKC_HI] && cnt_q[15:8] != 8'hff && !cnt_wr)
    |=> (cnt_q[15:8] == $past(cnt_q[15:8]) + 8'h01))
    else $error("high byte on system clock did not count");

  a_ext_shared: assert property ( // [RULE8]
    s_ext_both
    |=> (cnt_q == $past(cnt_q) + 16'h0101))
    else $error("external edge did not move both bytes");

  a_ext_idle: assert property ( // [RULE8]
    (ctrl_q[`TMC_CTRL_ECS] && ckc_q == 2'b00 && !tk.ext_rise && !cnt_wr)
    |=> $stable(cnt_q))
    else $error("counter moved without external edge");

  a_div_only: assert property ( // [RULE10]
    (!ctrl_q[`TMC_CTRL_ECS] && !split && run && ckc_q == 2'b00 && !tk.div_tick && !cnt_wr)
    |=> $stable(cnt_q))
    else $error("counter moved between divided ticks");

  // Only a write of one may clear a flag
  a_flag_sticky: assert property ( // [RULE11]
    (st_q[`TMC_ST_LO] && !(wr_acc && hit_st && wb_sel_i[0] && wb_dat_i[`TMC_ST_LO]))
    |=> st_q[`TMC_ST_LO])
    else $error("low overflow flag cleared by hardware");

  a_cap_flag: assert property ( // [RULE2]
    s_capture |=> st_q[`TMC_ST_CAP])
    else $error("capture flag not set");

  a_lo_irq_off: assert property ( // [RULE1]
    (!lbie && !mask_q[`TMC_ST_HI] && !(mask_q[`TMC_ST_CAP] && cap_en))
    |-> !irq_o)
    else $error("interrupt raised with low byte source disabled");

endmodule : tmc_timer2

`default_nettype wire

// ---- verilog/tmc_cfg.svh ----
`ifndef TMC_CFG_SVH
`define TMC_CFG_SVH

// Byte addresses of the register words
`define TMC_ADR_CTRL 8'h00
`define TMC_ADR_CNT 8'h04
`define TMC_ADR_RLD 8'h08
`define TMC_ADR_CKC 8'h0c
`define TMC_ADR_STAT 8'h10
`define TMC_ADR_MASK 8'h14

// Control register fields
`define TMC_CTRL_ECS 0
`define TMC_CTRL_UNUSED 1
`define TMC_CTRL_RUN 2
`define TMC_CTRL_SPLIT 3
`define TMC_CTRL_CAPEN 4
`define TMC_CTRL_LBIE 5
`define TMC_CTRL_WMASK 8'h3d
`define TMC_CTRL_RST 8'h00

// Clock control register fields
`define TMC_CKC_LO 0
`define TMC_CKC_HI 1
`define TMC_CKC_RST 2'h0

// Status and mask fields
`define TMC_ST_HI 0
`define TMC_ST_LO 1
`define TMC_ST_CAP 2
`define TMC_ST_RST 3'h0
`define TMC_MASK_RST 3'h0

// Counter and reload reset values
`define TMC_CNT_RST 16'h0000
`define TMC_RLD_RST 16'h0000

// System clock prescale for the default external tick
`define TMC_DIV_RATIO 12

`endif

// ---- verilog/tmc_pkg.sv ----
`default_nettype none
`include "tmc_cfg.svh"

package tmc_pkg;

  typedef logic [7:0] tmc_byte_t;
  typedef logic [15:0] tmc_word_t;
  typedef logic [2:0] tmc_stat_t;

  function automatic tmc_byte_t tmc_merge8(input tmc_byte_t old_v, input tmc_byte_t new_v,
                                           input logic en);
    tmc_byte_t r;
    r = en ? new_v : old_v;
    return r;
  endfunction : tmc_merge8

endpackage : tmc_pkg

`default_nettype wire

// ---- verilog/tmc_tick_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface tmc_tick_if;
  logic div_tick;
  logic ext_rise;
  logic lfo_fall;

  modport src (output div_tick, output ext_rise, output lfo_fall);
  modport snk (input div_tick, input ext_rise, input lfo_fall);
endinterface : tmc_tick_if

`default_nettype wire

// ---- verilog/tmc_tick_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tmc_cfg.svh"

module tmc_tick_gen #(
  parameter int DIV_RATIO = `TMC_DIV_RATIO
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ext_clk_i,
  input wire logic lfo_i,
  tmc_tick_if.src tk
);
  localparam int CW = $clog2(DIV_RATIO);

  // The spacing check counts in eight bits
  if (DIV_RATIO < 2 || DIV_RATIO > 256) begin : g_bad_div
    $error("tmc_tick_gen: DIV_RATIO must lie between 2 and 256");
  end

  logic [CW-1:0] div_q, div_d;
  logic ext_q, lfo_q;
  logic [7:0] gap_q, gap_d;
  logic seen_q, seen_d;

  always_comb begin
    div_d = (div_q == CW'(DIV_RATIO - 1)) ? '0 : div_q + CW'(1);
    gap_d = tk.div_tick ? 8'h00 : gap_q + 8'h01;
    seen_d = seen_q | tk.div_tick;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= '0;
      ext_q <= 1'b0;
      lfo_q <= 1'b0;
      gap_q <= 8'h00;
      seen_q <= 1'b0;
    end else begin
      div_q <= div_d;
      ext_q <= ext_clk_i;
      lfo_q <= lfo_i;
      gap_q <= gap_d;
      seen_q <= seen_d;
    end
  end

  // Divided system clock: one pulse every DIV_RATIO cycles
  assign tk.div_tick = (div_q == CW'(DIV_RATIO - 1)); // [RULE10]
  assign tk.ext_rise = ext_clk_i & ~ext_q;
  assign tk.lfo_fall = ~lfo_i & lfo_q;

  a_div_period: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE10]
    (tk.div_tick && seen_q) |-> (gap_q == 8'(DIV_RATIO - 1)))
    else $error("divided tick spacing wrong");

endmodule : tmc_tick_gen

`default_nettype wire

// ---- verification/tmc_timer2_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tmc_cfg.svh"

module tmc_timer2_tb;
  import tmc_pkg::*;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h3;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic ext_clk_i = 1'b0;
  logic lfo_i = 1'b0;
  tmc_word_t count_o;
  logic irq_o;
  int mismatches = 0;
  int tests_run = 0;

  always #50 clk_i = ~clk_i;

  tmc_timer2 #(.DIV_RATIO(12)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_clk_i(ext_clk_i), .lfo_i(lfo_i),
    .count_o(count_o), .irq_o(irq_o)
  );

  task automatic give_verdict;
    if (mismatches == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Entered just after a rising edge; leaves one idle edge after the ack edge
  task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    if (n >= 50) begin
      check("bus ack", 32'h0, 32'h1);
      give_verdict();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb_cycle

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_cycle(1'b1, a, d, q);
  endtask : wr

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb_cycle(1'b0, a, 32'h0, q);
    check(what, q, exp);
  endtask : rdchk

  // Values read right after an edge are those registered at the previous edge
  task automatic wait_cnt(input tmc_word_t v, input tmc_word_t m);
    int n;
    n = 0;
    while ((count_o & m) !== v && n < 600) begin
      @(posedge clk_i);
      n++;
    end
    check("count reached", {16'h0, count_o & m}, {16'h0, v});
  endtask : wait_cnt

  task automatic s_regs;
    rdchk("ctrl reset", `TMC_ADR_CTRL, 32'h0);
    rdchk("count reset", `TMC_ADR_CNT, 32'h0);
    rdchk("status reset", `TMC_ADR_STAT, 32'h0);
    check("irq reset", {31'h0, irq_o}, 32'h0);
    wr(`TMC_ADR_CTRL, 32'hff);
    rdchk("ctrl all ones", `TMC_ADR_CTRL, 32'h3d);
    wr(`TMC_ADR_CTRL, 32'h02);
    rdchk("ctrl unused bit", `TMC_ADR_CTRL, 32'h0);
    rdchk("unmapped", 8'h20, 32'h0);
  endtask : s_regs

  task automatic s_run16;
    wr(`TMC_ADR_CKC, 32'h1);
    wr(`TMC_ADR_RLD, 32'h1234);
    wr(`TMC_ADR_CNT, 32'hfef0);
    repeat (5) @(posedge clk_i);
    rdchk("stopped count", `TMC_ADR_CNT, 32'hfef0);
    wr(`TMC_ADR_CTRL, 32'h04);
    wait_cnt(16'hffff, 16'hffff);
    @(posedge clk_i);
    check("reload 16", {16'h0, count_o}, 32'h1234);
    wr(`TMC_ADR_CTRL, 32'h00);
    rdchk("flags 16", `TMC_ADR_STAT, 32'h3);
    wr(`TMC_ADR_MASK, 32'h2);
    check("irq low disabled", {31'h0, irq_o}, 32'h0);
    wr(`TMC_ADR_CTRL, 32'h20);
    check("irq low enabled", {31'h0, irq_o}, 32'h1);
    rdchk("flags kept", `TMC_ADR_STAT, 32'h3);
    wr(`TMC_ADR_STAT, 32'h7);
    check("irq cleared", {31'h0, irq_o}, 32'h0);
    rdchk("flags cleared", `TMC_ADR_STAT, 32'h0);
  endtask : s_run16

  task automatic s_split;
    wr(`TMC_ADR_CTRL, 32'h28);
    wr(`TMC_ADR_CKC, 32'h3);
    wr(`TMC_ADR_RLD, 32'h4080);
    wr(`TMC_ADR_CNT, 32'h40fe);
    wait_cnt(16'h40ff, 16'hffff);
    @(posedge clk_i);
    check("split low reload", {16'h0, count_o}, 32'h4080);
    check("split low irq", {31'h0, irq_o}, 32'h1);
    wr(`TMC_ADR_CNT, 32'hfe00);
    wr(`TMC_ADR_CTRL, 32'h0c);
    wait_cnt(16'hff00, 16'hff00);
    @(posedge clk_i);
    check("split high reload", {24'h0, count_o[15:8]}, 32'h40);
    wr(`TMC_ADR_CTRL, 32'h08);
    rdchk("split flags", `TMC_ADR_STAT, 32'h3);
  endtask : s_split

  task automatic s_clocks;
    int n;
    tmc_word_t c;
    wr(`TMC_ADR_CKC, 32'h0);
    wr(`TMC_ADR_CTRL, 32'h0d);
    wr(`TMC_ADR_CNT, 32'h1010);
    repeat (3) @(posedge clk_i);
    rdchk("no ext edge", `TMC_ADR_CNT, 32'h1010);
    ext_clk_i <= 1'b1;
    @(posedge clk_i);
    ext_clk_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rdchk("one ext edge", `TMC_ADR_CNT, 32'h1111);
    wr(`TMC_ADR_CTRL, 32'h04);
    for (int k = 0; k < 2; k++) begin
      c = count_o;
      n = 0;
      while (count_o === c && n < 40) begin
        @(posedge clk_i);
        n++;
      end
    end
    check("div tick spacing", n, 32'd12);
    wr(`TMC_ADR_CTRL, 32'h00);
  endtask : s_clocks

  task automatic s_capture;
    wr(`TMC_ADR_STAT, 32'h7);
    wr(`TMC_ADR_MASK, 32'h4);
    wr(`TMC_ADR_CNT, 32'hbeef);
    wr(`TMC_ADR_CTRL, 32'h10);
    lfo_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    lfo_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check("capture irq", {31'h0, irq_o}, 32'h1);
    rdchk("captured", `TMC_ADR_RLD, 32'hbeef);
    rdchk("capture flag", `TMC_ADR_STAT, 32'h4);
    wr(`TMC_ADR_STAT, 32'h7);
    wr(`TMC_ADR_CNT, 32'h5a5a);
    wr(`TMC_ADR_CTRL, 32'h00);
    lfo_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    lfo_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check("no capture irq", {31'h0, irq_o}, 32'h0);
    rdchk("reload kept", `TMC_ADR_RLD, 32'hbeef);
  endtask : s_capture

  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    give_verdict();
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    s_regs();
    s_run16();
    s_split();
    s_clocks();
    s_capture();
    give_verdict();
  end

endmodule : tmc_timer2_tb

`default_nettype wire
